// >>> sim/clock_tree_checker.sv
// concurrent checks on the clock tree outputs
// assumes binding into clock_tree_ctrl and a single aclk domain
`timescale 1ns/1ps
`default_nettype none

module clock_tree_checker #(
  parameter int ISRC_DIV     = 20,
  parameter int PLL_LOCK_CYC = 50
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // watched ports
  input wire logic sleep_wake,
  input wire logic ifrc_running,
  input wire logic sys_tick,
  input wire logic main_tick,
  input wire logic pb1_tick,
  input wire logic pb2_tick,
  input wire logic usb_tick,
  input wire logic wdg_tick
);
  int cnt_r;

  // cycles since reset release, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn)
      cnt_r <= 0;
    else if (cnt_r < 100000)
      cnt_r <= cnt_r + 1;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_sys_after_start: assert property (sys_tick |-> cnt_r >= 200)
    else $error("system tick before the fast rc settled");
  a_ifrc_starts: assert property (cnt_r == 260 |-> ifrc_running)
    else $error("fast rc not running after startup");
  a_main_from_sys: assert property (main_tick |-> $past(sys_tick))
    else $error("main tick without a system tick");
  a_pb1_from_main: assert property (pb1_tick |-> $past(main_tick))
    else $error("pb1 tick without a main tick");
  a_pb2_from_main: assert property (pb2_tick |-> $past(main_tick))
    else $error("pb2 tick without a main tick");
  a_wdg_slow_start: assert property (wdg_tick |-> cnt_r >= 390)
    else $error("watchdog tick before the slow rc settled");
  a_usb_after_lock: assert property (usb_tick |-> cnt_r > PLL_LOCK_CYC)
    else $error("usb tick before pll lock");
  a_wake_fast_rc: assert property (sleep_wake |-> ##[1:230] ifrc_running)
    else $error("fast rc not running after wake");
endmodule

bind clock_tree_ctrl clock_tree_checker #(
  .ISRC_DIV(ISRC_DIV),
  .PLL_LOCK_CYC(PLL_LOCK_CYC)
) u_chk (
  .aclk(aclk), .aresetn(aresetn), .sleep_wake(sleep_wake), .ifrc_running(ifrc_running),
  .sys_tick(sys_tick), .main_tick(main_tick), .pb1_tick(pb1_tick), .pb2_tick(pb2_tick),
  .usb_tick(usb_tick), .wdg_tick(wdg_tick)
);

`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for clock_tree_ctrl
// assumes clock_tree_defs.svh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "clock_tree_defs.svh"

module tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, sleep_wake;
  logic        s_axi_arvalid, s_axi_rready, efo_clk, efo_rdy, eso_clk, eso_rdy;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        efo_en, eso_en, ifrc_running;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, u;
  logic [3:0]  m;
  logic [2:0]  p, q;
  logic [6:0]  tk;
  int          bad_count, n_checks;

  clock_tree_ctrl #(.ISRC_DIV(30), .PLL_LOCK_CYC(50)) uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .efo_clk, .efo_rdy, .eso_clk, .eso_rdy,
    .efo_en, .eso_en, .sleep_wake, .ifrc_running, .sys_tick(tk[0]), .main_tick(tk[1]),
    .pb1_tick(tk[2]), .pb2_tick(tk[3]), .usb_tick(tk[4]), .rtc_tick(tk[5]), .wdg_tick(tk[6])
  );

  // ----------------------------------------------------------------
  // clocks, watchdog and helpers
  // ----------------------------------------------------------------
  // aclk 200 MHz, external fast pin 8 cycles, external slow pin 20 cycles
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    efo_clk = 1'b0;
    forever #20 efo_clk = ~efo_clk;
  end
  initial begin
    eso_clk = 1'b0;
    forever #50 eso_clk = ~eso_clk;
  end

  // cuts a hang short
  initial begin
    #300000;
    bad_count++;
    close_out();
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // cycles between two pulses of tick i, second interval kept
  task automatic gap(input int i);
    repeat (2) begin
      v = 0;
      @(posedge aclk);
      while (!tk[i]) @(posedge aclk);
      do begin
        @(posedge aclk);
        v = v + 1;
      end while (!tk[i]);
    end
  endtask

  function automatic logic [31:0] div_word(input logic [3:0] ms, input logic [2:0] ps,
                                           input logic [2:0] qs, input logic [1:0] us);
    return {18'h0, us, 1'b0, qs, 1'b0, ps, ms};
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, sleep_wake} = '0;
    {s_axi_arvalid, s_axi_rready, efo_rdy} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    eso_rdy = 1'b1;
    void'($urandom(32'h9163));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd({`OFS_CTRL, 2'b00});
    chk("ctrl reset", v, `CTRL_RST);
    rd({`OFS_DIV, 2'b00});
    chk("div reset", v, `DIV_RST);
    rd({`OFS_STEP, 2'b00});
    chk("step reset", v, `STEP_RST);
    rd(8'h40);
    chk("unmapped read resp", {30'h0, r}, 32'h2);
    wr(8'h40, 32'h1);
    chk("unmapped write resp", {30'h0, r}, 32'h2);
    while (!ifrc_running) @(posedge aclk);
    gap(0);
    chk("fast rc gap", v, 32'd25);
    repeat (3) begin
      m = 4'($urandom_range(3));
      p = 3'($urandom_range(2));
      q = 3'($urandom_range(2));
      u = 2'($urandom_range(3));
      d = div_word(m, p, q, u);
      wr({`OFS_DIV, 2'b00}, d);
      chk("div write resp", {30'h0, r}, 32'h0);
      rd({`OFS_DIV, 2'b00});
      chk("div readback", v, d);
      chk("div read resp", {30'h0, r}, 32'h0);
      gap(1);
      chk("main gap", v, 32'd25 << m);
      gap(2);
      chk("pb1 gap", v, 32'd25 << (m + p));
      gap(3);
      chk("pb2 gap", v, 32'd25 << (m + q));
    end
    wr({`OFS_CTRL, 2'b00}, 32'h0000_0105);
    repeat (50) @(posedge aclk);
    chk("efo pad enable", {31'h0, efo_en}, 32'h1);
    rd({`OFS_STATUS, 2'b00});
    chk("held on old source", {29'h0, v[10:8]}, 32'h4);
    efo_rdy <= 1'b1;
    repeat (60) @(posedge aclk);
    gap(0);
    chk("efo gap", v, 32'd8);
    rd({`OFS_STATUS, 2'b00});
    chk("efo active", {30'h0, v[9:8]}, 32'h1);
    sleep_wake <= 1'b1;
    @(posedge aclk);
    sleep_wake <= 1'b0;
    rd({`OFS_CTRL, 2'b00});
    chk("wake ctrl", v & 32'h0000_0301, 32'h1);
    gap(0);
    chk("wake gap", v, 32'd25);
    wr({`OFS_STEP, 2'b00}, 32'h0000_2000);
    wr({`OFS_DIV, 2'b00}, div_word(4'h0, 3'h0, 3'h0, 2'h1));
    wr({`OFS_CTRL, 2'b00}, 32'h0000_0211);
    repeat (100) @(posedge aclk);
    gap(0);
    chk("pll gap", v, 32'd8);
    gap(4);
    chk("usb gap", v, 32'd16);
    wr({`OFS_CTRL, 2'b00}, 32'h0000_100b);
    repeat (500) @(posedge aclk);
    chk("eso pad enable", {31'h0, eso_en}, 32'h1);
    gap(5);
    chk("rtc gap", v, 32'd20);
    gap(6);
    chk("watchdog gap", v, 32'd30);
    // select code 3 falls back to the fast rc, rtc back on the slow rc
    wr({`OFS_CTRL, 2'b00}, 32'h0000_0303);
    gap(5);
    chk("rtc slow rc gap", v, 32'd30);
    rd({`OFS_STATUS, 2'b00});
    chk("code 3 on fast rc", {29'h0, v[10:8]}, 32'h0);
    close_out();
  end
endmodule

`default_nettype wire

// >>> src/clock_tree_ctrl.sv
// clock tree control: sources, glitch-free system mux, bus prescalers, slow and usb ticks
// assumes one 200 MHz aclk; every derived clock is a one-cycle enable on aclk
//
// What this block does
// - four sources: internal fast rc, internal slow rc, external fast, external slow
// - system clock comes from internal fast rc, external fast or pll output
// - main bus and two peripheral buses derived from system clock by prescalers
// - a slow source feeds the real-time clock and independent watchdog
// - usb 48 MHz clock comes from the pll output through its own divider
// - wake from sleep forces the system clock back to internal fast rc
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "clock_tree_defs.svh"

module clock_tree_ctrl #(
  parameter int ISRC_DIV     = `ISRC_DIV_DFLT,
  parameter int PLL_LOCK_CYC = `PLL_LOCK_DFLT
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // external oscillator pads
  input  wire logic        efo_clk,
  input  wire logic        efo_rdy,
  input  wire logic        eso_clk,
  input  wire logic        eso_rdy,
  output logic             efo_en,
  output logic             eso_en,
  // power control
  input  wire logic        sleep_wake,
  output logic             ifrc_running,
  // clock enables
  output logic             sys_tick,
  output logic             main_tick,
  output logic             pb1_tick,
  output logic             pb2_tick,
  output logic             usb_tick,
  output logic             rtc_tick,
  output logic             wdg_tick
);

  // ----------------------------------------------------------------
  // pad synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pad_s1_r, pad_s2_r, pad_s3_r, pad_f_r, pad_d_r;
  logic [3:0] pad_in;
  logic       efo_tick, eso_tick;

  assign pad_in = {eso_rdy, eso_clk, efo_rdy, efo_clk};

  // three stages, a level counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_s1_r <= 4'h0;
      pad_s2_r <= 4'h0;
      pad_s3_r <= 4'h0;
      pad_f_r  <= 4'h0;
      pad_d_r  <= 4'h0;
    end else begin
      pad_s1_r <= pad_in;
      pad_s2_r <= pad_s1_r;
      pad_s3_r <= pad_s2_r;
      pad_f_r  <= (pad_s2_r & pad_s3_r) | (pad_f_r & (pad_s2_r | pad_s3_r));
      pad_d_r  <= pad_f_r;
    end
  end

  // rising edges of the external clocks become ticks
  assign efo_tick = pad_f_r[0] & ~pad_d_r[0] & efo_en;
  assign eso_tick = pad_f_r[2] & ~pad_d_r[2] & eso_en;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0]            ctrl_r, div_r, step_r;
  clock_tree_pkg::src_t   act_r, tgt_r, req_src;
  clock_tree_pkg::sw_state_t sw_r;
  clock_tree_pkg::osc_rdy_t  rdy;
  logic [31:0]            force_on;
  logic                   aw_have_r, w_have_r;
  logic [5:0]             aw_idx_r;
  logic [31:0]            wdata_r;
  logic [3:0]             wstrb_r;
  logic                   wr_go;
  logic [5:0]             ar_idx;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // unknown select code falls back to internal fast rc
  always_comb begin
    case (ctrl_r[`CTRL_SEL_LO +: 2])
      2'h1:    req_src = clock_tree_pkg::SRC_EFO;
      2'h2:    req_src = clock_tree_pkg::SRC_PLL;
      default: req_src = clock_tree_pkg::SRC_IFRC;
    endcase
  end

  // the source feeding the mux, or about to, cannot be switched off
  always_comb begin
    force_on = 32'h0000_0000;
    case (act_r)
      clock_tree_pkg::SRC_EFO: force_on[`CTRL_EFO_ON] = 1'b1;
      clock_tree_pkg::SRC_PLL: force_on[`CTRL_PLL_ON] = 1'b1;
      default:                 force_on[`CTRL_IFRC_ON] = 1'b1;
    endcase
    if (sw_r == clock_tree_pkg::SW_WAIT_NEW || sw_r == clock_tree_pkg::SW_WAIT_OLD) begin
      case (tgt_r)
        clock_tree_pkg::SRC_EFO: force_on[`CTRL_EFO_ON] = 1'b1;
        clock_tree_pkg::SRC_PLL: force_on[`CTRL_PLL_ON] = 1'b1;
        default:                 force_on[`CTRL_IFRC_ON] = 1'b1;
      endcase
    end
  end

  assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;

  // control register; a wake beats a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `CTRL_RST;
    end else begin
      if (wr_go && aw_idx_r == `OFS_CTRL) begin
        ctrl_r <= (merge(ctrl_r, wdata_r, wstrb_r) & `CTRL_MASK) | force_on;
      end else begin
        ctrl_r <= ctrl_r | force_on;
      end
      if (sleep_wake) begin
        ctrl_r[`CTRL_SEL_LO +: 2] <= 2'h0;
        ctrl_r[`CTRL_IFRC_ON]     <= 1'b1;
      end
    end
  end

  // divider and pll step registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r  <= `DIV_RST;
      step_r <= `STEP_RST;
    end else if (wr_go) begin
      if (aw_idx_r == `OFS_DIV) begin
        div_r <= merge(div_r, wdata_r, wstrb_r) & `DIV_MASK;
      end
      if (aw_idx_r == `OFS_STEP) begin
        step_r <= merge(step_r, wdata_r, wstrb_r) & `STEP_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  // address and data are taken in either order, the response follows both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_idx_r      <= 6'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= ~aw_have_r & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_have_r & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_idx_r  <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_idx_r <= `OFS_STEP) ? 2'h0 : 2'h2;
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign ar_idx = s_axi_araddr[7:2];

  // one read at a time; status is read-only, unmapped reads zero with slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (ar_idx)
          `OFS_CTRL:   s_axi_rdata <= ctrl_r;
          `OFS_DIV:    s_axi_rdata <= div_r;
          `OFS_STEP:   s_axi_rdata <= step_r;
          `OFS_STATUS: s_axi_rdata <= {21'h0, (sw_r != clock_tree_pkg::SW_RUN),
                                       logic'(act_r[1]), logic'(act_r[0]), 3'h0, rdy};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // sources
  // ----------------------------------------------------------------
  logic [15:0] ifrc_cnt_r, isrc_cnt_r, pll_cnt_r;
  logic [16:0] pll_acc_r;
  logic        ifrc_tick, isrc_tick, pll_tick;

  // startup counters: a source is ready once its settling time has passed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ifrc_cnt_r <= 16'h0000;
      isrc_cnt_r <= 16'h0000;
      pll_cnt_r  <= 16'h0000;
    end else begin
      if (!ctrl_r[`CTRL_IFRC_ON]) ifrc_cnt_r <= 16'h0000;
      else if (!rdy.ifrc) ifrc_cnt_r <= ifrc_cnt_r + 16'h0001;
      if (!ctrl_r[`CTRL_ISRC_ON]) isrc_cnt_r <= 16'h0000;
      else if (!rdy.isrc) isrc_cnt_r <= isrc_cnt_r + 16'h0001;
      if (!ctrl_r[`CTRL_PLL_ON]) pll_cnt_r <= 16'h0000;
      else if (!rdy.pll) pll_cnt_r <= pll_cnt_r + 16'h0001;
    end
  end

  assign rdy.ifrc = ifrc_cnt_r >= 16'(`IFRC_START_CYC);
  assign rdy.isrc = isrc_cnt_r >= 16'(`ISRC_START_CYC);
  assign rdy.efo  = efo_en & pad_f_r[1];
  assign rdy.eso  = eso_en & pad_f_r[3];
  assign rdy.pll  = pll_cnt_r >= 16'(PLL_LOCK_CYC);

  // pll output rate is step/65536 of aclk, carry out is the tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_acc_r <= 17'h0_0000;
    end else if (rdy.pll) begin
      pll_acc_r <= {1'b0, pll_acc_r[15:0]} + {1'b0, step_r[15:0]};
    end else begin
      pll_acc_r <= 17'h0_0000;
    end
  end

  assign pll_tick = pll_acc_r[16];

  // pad enables and fast rc running status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      efo_en       <= 1'b0;
      eso_en       <= 1'b0;
      ifrc_running <= 1'b0;
    end else begin
      efo_en       <= ctrl_r[`CTRL_EFO_ON];
      eso_en       <= ctrl_r[`CTRL_ESO_ON];
      ifrc_running <= rdy.ifrc;
    end
  end

  tick_divider #(.W(5)) u_ifrc (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .tick_in  (rdy.ifrc),
    .ratio    (5'(`IFRC_RATIO)),
    .tick_out (ifrc_tick)
  );

  tick_divider #(.W(13)) u_isrc (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .tick_in  (rdy.isrc),
    .ratio    (13'(ISRC_DIV - 1)),
    .tick_out (isrc_tick)
  );

  // ----------------------------------------------------------------
  // glitch-free system clock mux
  // ----------------------------------------------------------------
  function automatic logic src_tk(input clock_tree_pkg::src_t s, input logic a,
                                  input logic b, input logic c);
    case (s)
      clock_tree_pkg::SRC_EFO: return b;
      clock_tree_pkg::SRC_PLL: return c;
      default:                 return a;
    endcase
  endfunction

  function automatic logic src_rd(input clock_tree_pkg::src_t s,
                                  input clock_tree_pkg::osc_rdy_t r);
    case (s)
      clock_tree_pkg::SRC_EFO: return r.efo;
      clock_tree_pkg::SRC_PLL: return r.pll;
      default:                 return r.ifrc;
    endcase
  endfunction

  logic old_tk, new_tk;
  logic new_seen_r;
  assign old_tk = src_tk(act_r, ifrc_tick, efo_tick, pll_tick);
  assign new_tk = src_tk(tgt_r, ifrc_tick, efo_tick, pll_tick);

  // old source ends a whole period; the new one's first tick may sit right
  // behind the old one's, so it is swallowed and the second tick passes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_r     <= clock_tree_pkg::SW_RUN;
      act_r    <= clock_tree_pkg::SRC_IFRC;
      tgt_r    <= clock_tree_pkg::SRC_IFRC;
      sys_tick <= 1'b0;
      new_seen_r <= 1'b0;
    end else begin
      sys_tick <= 1'b0;
      case (sw_r)
        clock_tree_pkg::SW_RUN: begin
          sys_tick <= old_tk;
          if (req_src != act_r) sw_r <= clock_tree_pkg::SW_WAIT_RDY;
        end
        clock_tree_pkg::SW_WAIT_RDY: begin
          sys_tick <= old_tk;
          if (req_src == act_r) begin
            sw_r <= clock_tree_pkg::SW_RUN;
          end else if (src_rd(req_src, rdy)) begin
            tgt_r <= req_src;
            sw_r  <= clock_tree_pkg::SW_WAIT_OLD;
          end
        end
        clock_tree_pkg::SW_WAIT_OLD: begin
          sys_tick   <= old_tk;
          new_seen_r <= 1'b0;
          if (old_tk || !src_rd(act_r, rdy)) sw_r <= clock_tree_pkg::SW_WAIT_NEW;
        end
        clock_tree_pkg::SW_WAIT_NEW: begin
          if (new_tk && new_seen_r) begin
            sys_tick <= 1'b1;
            act_r    <= tgt_r;
            sw_r     <= clock_tree_pkg::SW_RUN;
          end else if (new_tk) begin
            new_seen_r <= 1'b1;
          end
        end
        default: sw_r <= clock_tree_pkg::SW_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bus prescalers, usb and slow ticks
  // ----------------------------------------------------------------
  logic [3:0] main_sh;
  logic [2:0] pb1_sh, pb2_sh;
  logic [8:0] main_ratio, pb1_ratio, pb2_ratio;

  // power-of-two prescale, oversized codes clamp to the largest ratio
  always_comb begin
    main_sh    = (div_r[`DIV_MAIN_LO +: 4] > `MAIN_SHIFT_MAX) ? `MAIN_SHIFT_MAX
                                                              : div_r[`DIV_MAIN_LO +: 4];
    pb1_sh     = (div_r[`DIV_PB1_LO +: 3] > `PB_SHIFT_MAX) ? `PB_SHIFT_MAX
                                                           : div_r[`DIV_PB1_LO +: 3];
    pb2_sh     = (div_r[`DIV_PB2_LO +: 3] > `PB_SHIFT_MAX) ? `PB_SHIFT_MAX
                                                           : div_r[`DIV_PB2_LO +: 3];
    main_ratio = 9'((10'h001 << main_sh) - 10'h001);
    pb1_ratio  = 9'((10'h001 << pb1_sh) - 10'h001);
    pb2_ratio  = 9'((10'h001 << pb2_sh) - 10'h001);
  end

  // main bus from system clock, peripheral buses from main bus
  tick_divider #(.W(9)) u_main (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .tick_in  (sys_tick),
    .ratio    (main_ratio),
    .tick_out (main_tick)
  );

  tick_divider #(.W(9)) u_pb1 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .tick_in  (main_tick),
    .ratio    (pb1_ratio),
    .tick_out (pb1_tick)
  );

  tick_divider #(.W(9)) u_pb2 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .tick_in  (main_tick),
    .ratio    (pb2_ratio),
    .tick_out (pb2_tick)
  );

  // usb reference from the pll output only
  tick_divider #(.W(2)) u_usb (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .tick_in  (pll_tick),
    .ratio    (div_r[`DIV_USB_LO +: 2]),
    .tick_out (usb_tick)
  );

  // rtc takes the selected slow source, the watchdog the internal slow rc
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rtc_tick <= 1'b0;
      wdg_tick <= 1'b0;
    end else begin
      rtc_tick <= ctrl_r[`CTRL_RTC_SEL] ? eso_tick : isrc_tick;
      wdg_tick <= isrc_tick;
    end
  end

endmodule

`default_nettype wire

// >>> src/clock_tree_defs.svh
// register offsets, field positions, reset values and timing counts of the clock tree
// assumes a 200 MHz aclk and a 32-bit AXI4-Lite register port
`ifndef CLOCK_TREE_DEFS_SVH
`define CLOCK_TREE_DEFS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ          200
`define IFRC_MHZ         8
`define IFRC_RATIO       ((`CLK_MHZ / `IFRC_MHZ) - 1)
`define ISRC_KHZ         40
`define ISRC_DIV_DFLT    ((`CLK_MHZ * 1000) / `ISRC_KHZ)
`define IFRC_START_NS    1000
`define IFRC_START_CYC   ((`IFRC_START_NS * `CLK_MHZ + 999) / 1000)
`define ISRC_START_NS    2000
`define ISRC_START_CYC   ((`ISRC_START_NS * `CLK_MHZ + 999) / 1000)
`define PLL_LOCK_US      100
`define PLL_LOCK_DFLT    (`PLL_LOCK_US * `CLK_MHZ)

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_CTRL         6'h00
`define OFS_DIV          6'h01
`define OFS_STEP         6'h02
`define OFS_STATUS       6'h03

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_IFRC_ON     0
`define CTRL_ISRC_ON     1
`define CTRL_EFO_ON      2
`define CTRL_ESO_ON      3
`define CTRL_PLL_ON      4
`define CTRL_SEL_LO      8
`define CTRL_RTC_SEL     12
`define CTRL_RST         32'h0000_0001
`define CTRL_MASK        32'h0000_131f

// ----------------------------------------------------------------
// divider register fields
// ----------------------------------------------------------------
`define DIV_MAIN_LO      0
`define DIV_PB1_LO       4
`define DIV_PB2_LO       8
`define DIV_USB_LO       12
`define DIV_RST          32'h0000_0000
`define DIV_MASK         32'h0000_377f
`define MAIN_SHIFT_MAX   4'h8
`define PB_SHIFT_MAX     3'h4

// ----------------------------------------------------------------
// pll step register and status fields
// ----------------------------------------------------------------
`define STEP_RST         32'h0000_0000
`define STEP_MASK        32'h0000_ffff
`define STAT_ACT_LO      8
`define STAT_BUSY        10

`endif

// >>> src/clock_tree_pkg.sv
// types shared by the clock tree files
// assumes clock_tree_defs.svh for numeric constants
package clock_tree_pkg;

  // system clock sources
  typedef enum logic [1:0] {
    SRC_IFRC,
    SRC_EFO,
    SRC_PLL
  } src_t;

  // glitch-free switch states
  typedef enum logic [1:0] {
    SW_RUN,
    SW_WAIT_RDY,
    SW_WAIT_OLD,
    SW_WAIT_NEW
  } sw_state_t;

  // ready flags of all sources
  typedef struct packed {
    logic pll;
    logic eso;
    logic efo;
    logic isrc;
    logic ifrc;
  } osc_rdy_t;

endpackage

// >>> src/tick_divider.sv
// tick divider: passes one of every ratio+1 input ticks
// assumes tick_in is a one-cycle enable on aclk
`timescale 1ns/1ps
`default_nettype none

module tick_divider #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // ticks
  input  wire logic         tick_in,
  input  wire logic [W-1:0] ratio,
  output logic              tick_out
);

  logic [W-1:0] cnt_r;

  // count input ticks, a shrinking ratio takes effect at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r    <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (cnt_r >= ratio) begin
          cnt_r    <= '0;
          tick_out <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire
